// file: logic/swd_consts.vh
`ifndef SWD_CONSTS_VH
`define SWD_CONSTS_VH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define SWD_CLK_MHZ      250
`define SWD_TICK_US      1000

// ****************************************************************
// APB register offsets
// ****************************************************************
`define SWD_AW           8
`define SWD_A_CFG        8'h00
`define SWD_A_BLOCK      8'h04
`define SWD_A_SWITCH     8'h08
`define SWD_A_STATUS     8'h0C
`define SWD_A_OBJNUM     8'h10

// ****************************************************************
// Configuration fields and reset value
// ****************************************************************
`define SWD_CFG_W        24
`define SWD_F_LONG       4:0
`define SWD_F_REP        9:5
`define SWD_F_DEB        12:10
`define SWD_F_SHORT      14:13
`define SWD_F_DIR        17:15
`define SWD_F_MODE       18
`define SWD_F_STEP       21:19
`define SWD_F_CONTACT    22
`define SWD_F_ONLYDIM    23
`define SWD_CFG_RST      24'h01_4063

// ****************************************************************
// Encodings
// ****************************************************************
`define SWD_SH_ON        2'h0
`define SWD_SH_OFF       2'h1
`define SWD_SH_TOGGLE    2'h2
`define SWD_DIR_BRIGHT   3'h0
`define SWD_DIR_DARK     3'h1
`define SWD_DIR_ALT      3'h2
`define SWD_DIR_ALT_BON  3'h3
`define SWD_DIR_ALT_DON  3'h4
`define SWD_DIM_STOP     4'h0
`define SWD_STEP_FULL    3'h1
`define SWD_STEP_MAX     3'h7
`define SWD_UP           1'b1

// ****************************************************************
// Object numbering
// ****************************************************************
`define SWD_OBJ_FIRST    7'h0A
`define SWD_OBJ_STRIDE   7'h0A
`define SWD_OBJ_BLOCK    7'h00
`define SWD_OBJ_SWITCH   7'h01
`define SWD_OBJ_DIM      7'h02

`endif

// file: logic/swd_tick.v
`timescale 1ns/100ps
`default_nettype none

module swd_tick #(
    parameter integer TICK_CYC = 250000
) (
    input  wire        pclk,
    input  wire        presetn,
    output reg         tick_r
);

    reg  [31:0] cnt_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else if (cnt_r == TICK_CYC - 1) begin
            cnt_r  <= 32'h0000_0000;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

endmodule // swd_tick

`default_nettype wire

// file: logic/swd_debounce.v
`timescale 1ns/100ps
`default_nettype none

module swd_debounce (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        tick,
    input  wire        en,
    input  wire [2:0]  deb_sel,
    input  wire        din,
    output reg         lvl_r,
    output reg         rdy_r
);

    reg  [7:0]  hold_r;

    function [7:0] deb_ms;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    deb_ms = 8'h0A;
                3'h1:    deb_ms = 8'h14;
                3'h2:    deb_ms = 8'h1E;
                3'h3:    deb_ms = 8'h32;
                3'h4:    deb_ms = 8'h46;
                3'h5:    deb_ms = 8'h64;
                default: deb_ms = 8'h96;
            endcase
        end
    endfunction

    // The first edge passes at once; the hold window then masks the pin.
    // One extra tick is loaded so a partial first millisecond never
    // shortens the window. While disabled the pin and window freeze.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r  <= 1'b0;
            rdy_r  <= 1'b0;
            hold_r <= 8'h00;
        end else if (!rdy_r) begin
            lvl_r  <= din;
            rdy_r  <= 1'b1;
        end else if (en) begin
            if (hold_r == 8'h00) begin
                if (din != lvl_r) begin
                    lvl_r  <= din;
                    hold_r <= deb_ms(deb_sel) + 8'h01;
                end
            end else if (tick) begin
                hold_r <= hold_r - 8'h01;
            end
        end
    end

endmodule // swd_debounce

`default_nettype wire

// file: logic/swd_sensor.v
// Function
// - Press is long after selectable 0.3 to 10 s threshold, else short.
// - Short press sends ON, OFF, toggled value, or nothing.
// - Fixed direction setting always dims brighter or always darker.
// - Alternating setting sends opposite of last dimming direction.
// - Brighter-after-ON setting dims brighter first after an ON.
// - Darker-after-ON setting dims darker first after an ON.
// - Start/stop mode sends direction at long start, stop at release.
// - Dim code: stop 0000/1000, darker 0001, brighter 1001.
// - Stepwise mode repeats telegrams during long press, stops at release.
// - Stepwise telegram carries selectable step 100 down to 1.56 percent.
// - Stepwise repeat interval selectable 0.3 to 10 s.
// - Blocked input ignores pin, freezes timing, pauses stepping.
// - Switch object stays writable while blocked.
// - On unblock a changed level is processed at once.
// - Block does not affect manual operation.
// - Switch object bus-writable; write feeds toggle and stops stepping.
// - Input n owns object numbers ten per input, from 10 to 89.
// - Long press makes the 4-bit dim object transmit.
// - React to edge at once, then ignore edges for debounce time.
// - Contact type picks closing or opening as actuation.
// - Dim-and-switch splits short/long; dim-only dims at once.
// - Single-button dimming sends brighter while switch value is 0.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "swd_consts.vh"

module swd_sensor #(
    parameter [2:0]    INPUT_NUM = 3'h0,
    parameter integer  TICK_CYC  = `SWD_TICK_US * `SWD_CLK_MHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        pin_in,
    input  wire        manual_en,
    input  wire        manual_act,
    output reg         tx_sw_stb_r,
    output reg         tx_sw_val_r,
    output reg         tx_dim_stb_r,
    output reg  [3:0]  tx_dim_val_r,
    output reg  [6:0]  tx_obj_r
);

    // ************************************************************
    // States and object numbers
    // ************************************************************
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_PRESS = 2'h1;
    localparam [1:0] ST_DIM   = 2'h2;
    localparam [1:0] ST_HOLD  = 2'h3;

    localparam [6:0] OBJ_BASE = `SWD_OBJ_FIRST
                              + `SWD_OBJ_STRIDE * {4'h0, INPUT_NUM};
    localparam [6:0] OBJ_BLK  = OBJ_BASE + `SWD_OBJ_BLOCK;
    localparam [6:0] OBJ_SW   = OBJ_BASE + `SWD_OBJ_SWITCH;
    localparam [6:0] OBJ_DIM  = OBJ_BASE + `SWD_OBJ_DIM;

    reg  [`SWD_CFG_W-1:0] cfg_r;
    reg         blk_r;
    reg         sw_r;
    reg         last_dir_r;
    reg         after_on_r;
    reg  [1:0]  state_r;
    reg  [13:0] ms_r;
    reg         act_prev_r;
    reg         armed_r;
    reg  [3:0]  last_dim_r;

    wire        tick;
    wire        phys_lvl;
    wire        phys_rdy;

    // ************************************************************
    // Time lookup
    // ************************************************************
    function [13:0] sel_ms;
        input [4:0] sel;
        begin
            case (sel)
                5'h00:   sel_ms = 14'h012C;
                5'h01:   sel_ms = 14'h0190;
                5'h02:   sel_ms = 14'h01F4;
                5'h03:   sel_ms = 14'h0258;
                5'h04:   sel_ms = 14'h0320;
                5'h05:   sel_ms = 14'h03E8;
                5'h06:   sel_ms = 14'h04B0;
                5'h07:   sel_ms = 14'h05DC;
                5'h08:   sel_ms = 14'h07D0;
                5'h09:   sel_ms = 14'h0BB8;
                5'h0A:   sel_ms = 14'h0FA0;
                5'h0B:   sel_ms = 14'h1388;
                5'h0C:   sel_ms = 14'h1770;
                5'h0D:   sel_ms = 14'h1B58;
                5'h0E:   sel_ms = 14'h1F40;
                5'h0F:   sel_ms = 14'h2328;
                default: sel_ms = 14'h2710;
            endcase
        end
    endfunction

    // ************************************************************
    // Time base and debounced pin
    // ************************************************************
    swd_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_r   (tick)
    );

    // Blocking detaches the terminals from the evaluation, so the pin
    // level freezes and a changed level shows as an edge on release.
    swd_debounce u_deb (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .en       (~blk_r),
        .deb_sel  (cfg_r[`SWD_F_DEB]),
        .din      (pin_in),
        .lvl_r    (phys_lvl),
        .rdy_r    (phys_rdy)
    );

    // ************************************************************
    // Actuation and events
    // ************************************************************
    wire phys_act = phys_lvl ^ cfg_r[`SWD_F_CONTACT];
    wire act      = manual_en ? manual_act : phys_act;
    wire susp     = blk_r & ~manual_en;
    wire press    = armed_r & act & ~act_prev_r;
    wire unpress  = armed_r & ~act & act_prev_r;
    wire run_tick = tick & ~susp;

    wire [13:0] long_ms = sel_ms(cfg_r[`SWD_F_LONG]);
    wire [13:0] rep_ms  = sel_ms(cfg_r[`SWD_F_REP]);
    wire [13:0] ms_inc  = ms_r + 14'h0001;
    wire        step_md = cfg_r[`SWD_F_MODE];
    wire [2:0]  dir_md  = cfg_r[`SWD_F_DIR];
    wire [2:0]  step_ix = cfg_r[`SWD_F_STEP];

    // Index 0 is the full step; each higher index up to 6 halves it, and 7 gives the same step as 6.
    wire [2:0]  step_cd = (step_ix == `SWD_STEP_MAX) ? `SWD_STEP_MAX
                        : step_ix + `SWD_STEP_FULL;
    wire [2:0]  amount  = step_md ? step_cd
                                  : `SWD_STEP_FULL;

    reg         new_dir;
    always @* begin
        case (dir_md)
            `SWD_DIR_BRIGHT: new_dir = `SWD_UP;
            `SWD_DIR_DARK:   new_dir = ~`SWD_UP;
            `SWD_DIR_ALT_BON:
                new_dir = after_on_r ? `SWD_UP
                        : (~sw_r | ~last_dir_r);
            `SWD_DIR_ALT_DON:
                new_dir = after_on_r ? ~`SWD_UP
                        : (~sw_r | ~last_dir_r);
            default:
                new_dir = ~sw_r | ~last_dir_r;
        endcase
    end

    wire [3:0]  start_val = {new_dir, amount};
    wire [3:0]  rep_val   = {last_dir_r, amount};

    // ************************************************************
    // APB slave
    // ************************************************************
    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire a_cfg  = paddr == `SWD_A_CFG;
    wire a_blk  = paddr == `SWD_A_BLOCK;
    wire a_sw   = paddr == `SWD_A_SWITCH;
    wire a_stat = paddr == `SWD_A_STATUS;
    wire a_obj  = paddr == `SWD_A_OBJNUM;
    wire a_rw   = a_cfg | a_blk | a_sw;
    wire a_ok   = a_rw | ((a_stat | a_obj) & ~pwrite);
    wire wr     = access & pwrite & a_ok;

    assign pready  = 1'b1;
    assign pslverr = access & ~a_ok;

    // Read data is captured in the setup cycle, so every access phase
    // completes in one cycle with data already on a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            case (1'b1)
                a_cfg:  prdata <= {8'h00, cfg_r};
                a_blk:  prdata <= {31'h0000_0000, blk_r};
                a_sw:   prdata <= {31'h0000_0000, sw_r};
                a_stat: prdata <= {22'h00_0000, last_dim_r, after_on_r,
                                   last_dir_r, state_r, susp, act};
                a_obj:  prdata <= {8'h00, 1'b0, OBJ_DIM, 1'b0, OBJ_SW,
                                   1'b0, OBJ_BLK};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= `SWD_CFG_RST;
            blk_r <= 1'b0;
        end else if (wr) begin
            if (a_cfg)
                cfg_r <= pwdata[`SWD_CFG_W-1:0];
            if (a_blk)
                blk_r <= pwdata[0];
        end
    end

    // ************************************************************
    // Press evaluation and telegrams
    // ************************************************************
    wire sw_wr = wr & a_sw;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r      <= 1'b0;
            act_prev_r   <= 1'b0;
            state_r      <= ST_IDLE;
            ms_r         <= 14'h0000;
            sw_r         <= 1'b0;
            last_dir_r   <= 1'b0;
            after_on_r   <= 1'b0;
            last_dim_r   <= `SWD_DIM_STOP;
            tx_sw_stb_r  <= 1'b0;
            tx_sw_val_r  <= 1'b0;
            tx_dim_stb_r <= 1'b0;
            tx_dim_val_r <= `SWD_DIM_STOP;
            tx_obj_r     <= 7'h00;
        end else begin
            armed_r      <= phys_rdy;
            act_prev_r   <= act;
            tx_sw_stb_r  <= 1'b0;
            tx_dim_stb_r <= 1'b0;
            // A bus write updates the value and after_on_r, halts stepwise repeats, and sends nothing.
            if (sw_wr) begin
                sw_r       <= pwdata[0];
                after_on_r <= pwdata[0];
            end
            case (state_r)
                ST_IDLE: begin
                    ms_r <= 14'h0000;
                    if (press) begin
                        if (cfg_r[`SWD_F_ONLYDIM]) begin
                            state_r      <= ST_DIM;
                            last_dir_r   <= new_dir;
                            after_on_r   <= 1'b0;
                            last_dim_r   <= start_val;
                            tx_dim_stb_r <= 1'b1;
                            tx_dim_val_r <= start_val;
                            tx_obj_r     <= OBJ_DIM;
                        end else begin
                            state_r <= ST_PRESS;
                        end
                    end
                end
                ST_PRESS: begin
                    if (unpress) begin
                        state_r <= ST_IDLE;
                        if (cfg_r[`SWD_F_SHORT] != 2'h3) begin
                            tx_sw_stb_r <= 1'b1;
                            tx_obj_r    <= OBJ_SW;
                        end
                        case (cfg_r[`SWD_F_SHORT])
                            `SWD_SH_ON: begin
                                sw_r        <= 1'b1;
                                tx_sw_val_r <= 1'b1;
                                after_on_r  <= 1'b1;
                            end
                            `SWD_SH_OFF: begin
                                sw_r        <= 1'b0;
                                tx_sw_val_r <= 1'b0;
                                after_on_r  <= 1'b0;
                            end
                            `SWD_SH_TOGGLE: begin
                                sw_r        <= ~sw_r;
                                tx_sw_val_r <= ~sw_r;
                                after_on_r  <= ~sw_r;
                            end
                            default: ;
                        endcase
                    end else if (run_tick) begin
                        if (ms_inc >= long_ms) begin
                            state_r      <= ST_DIM;
                            ms_r         <= 14'h0000;
                            last_dir_r   <= new_dir;
                            after_on_r   <= 1'b0;
                            last_dim_r   <= start_val;
                            tx_dim_stb_r <= 1'b1;
                            tx_dim_val_r <= start_val;
                            tx_obj_r     <= OBJ_DIM;
                        end else begin
                            ms_r <= ms_inc;
                        end
                    end
                end
                ST_DIM: begin
                    if (unpress) begin
                        state_r <= ST_IDLE;
                        if (!step_md) begin
                            last_dim_r   <= `SWD_DIM_STOP;
                            tx_dim_stb_r <= 1'b1;
                            tx_dim_val_r <= `SWD_DIM_STOP;
                            tx_obj_r     <= OBJ_DIM;
                        end
                    end else if (step_md && sw_wr) begin
                        state_r <= ST_HOLD;
                    end else if (step_md && run_tick) begin
                        if (ms_inc >= rep_ms) begin
                            ms_r         <= 14'h0000;
                            last_dim_r   <= rep_val;
                            tx_dim_stb_r <= 1'b1;
                            tx_dim_val_r <= rep_val;
                            tx_obj_r     <= OBJ_DIM;
                        end else begin
                            ms_r <= ms_inc;
                        end
                    end
                end
                ST_HOLD: begin
                    if (unpress)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // swd_sensor

`default_nettype wire

// file: testbench/swd_sensor_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module swd_sensor_chk #(
    parameter [2:0] INPUT_NUM = 3'h0
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        manual_en,
    input wire logic        tx_sw_stb_r,
    input wire logic        tx_sw_val_r,
    input wire logic        tx_dim_stb_r,
    input wire logic [3:0]  tx_dim_val_r,
    input wire logic [6:0]  tx_obj_r
);
    // ********
    // Bus decode and block object copy
    // ********
    wire [6:0] base = 7'h0A * ({4'h0, INPUT_NUM} + 7'h01);
    wire       acc  = psel && penable;
    wire       rd   = acc && !pwrite;
    wire       bad  = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
    logic      blk_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            blk_r <= 1'b0;
        else if (acc && pwrite && paddr == 8'h04)
            blk_r <= pwdata[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // Properties
    // ********
    property p_err;
        acc |-> pslverr == (bad || (pwrite && paddr[7:2] >= 6'h03));
    endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
    property p_objrd;
        rd && paddr == 8'h10 |-> prdata ==
            {9'h000, base + 7'h02, 1'b0, base + 7'h01, 1'b0, base};
    endproperty
    a_objrd: assert property (p_objrd) else $error("object numbers");
    property p_blkrd;
        rd && paddr == 8'h04 |-> prdata == {31'h0000_0000, blk_r};
    endproperty
    a_blkrd: assert property (p_blkrd) else $error("block readback");
    property p_swobj;
        tx_sw_stb_r |-> tx_obj_r == base + 7'h01;
    endproperty
    a_swobj: assert property (p_swobj) else $error("switch object");
    property p_dimobj;
        tx_dim_stb_r |-> tx_obj_r == base + 7'h02;
    endproperty
    a_dimobj: assert property (p_dimobj) else $error("dim object");
    property p_code;
        tx_dim_stb_r && tx_dim_val_r[2:0] == 3'h0 |-> !tx_dim_val_r[3];
    endproperty
    a_code: assert property (p_code) else $error("stop code");
    property p_pulse;
        tx_dim_stb_r |=> !tx_dim_stb_r;
    endproperty
    a_pulse: assert property (p_pulse) else $error("dim strobe long");
    property p_swhold;
        $changed(tx_sw_val_r) |-> tx_sw_stb_r;
    endproperty
    a_swhold: assert property (p_swhold) else $error("switch value");
    property p_blk;
        (blk_r && !manual_en) [*3] |-> !tx_dim_stb_r && !tx_sw_stb_r;
    endproperty
    a_blk: assert property (p_blk) else $error("sent while blocked");
    c_step: cover property (tx_dim_stb_r && tx_dim_val_r[2:0] != 3'h1);
    c_blk: cover property (blk_r && rd);
    c_off: cover property (tx_sw_stb_r && !tx_sw_val_r);
endmodule // swd_sensor_chk
bind swd_sensor swd_sensor_chk #(.INPUT_NUM(INPUT_NUM)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .manual_en(manual_en), .tx_sw_stb_r(tx_sw_stb_r),
    .tx_sw_val_r(tx_sw_val_r), .tx_dim_stb_r(tx_dim_stb_r),
    .tx_dim_val_r(tx_dim_val_r), .tx_obj_r(tx_obj_r));
`default_nettype wire

// file: testbench/swd_act_model.sv
`timescale 1ns/100ps
`default_nettype none
module swd_act_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sw_stb,
    input  wire logic       sw_val,
    input  wire logic       dim_stb,
    input  wire logic [3:0] dim_val,
    output var  logic       on_r
);
    // ********
    // Switching state fed back to the sensor
    // ********
    // Dimming up from off switches the load on; only this feedback keeps
    // a later toggle from sending the stale value.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            on_r <= 1'b0;
        else if (sw_stb)
            on_r <= sw_val;
        else if (dim_stb && dim_val[3])
            on_r <= 1'b1;
endmodule // swd_act_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ********
    // Signals, block under test and far side
    // ********
    logic        pclk, presetn, psel, penable, pwrite, pin_in;
    logic        pready, pslverr, sw_stb, sw_val, dim_stb, fb_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  dim_val;
    logic [4:0]  e;
    logic [4:0]  lt [7] = '{5'h01, 5'h04, 5'h09, 5'h08, 5'h0F, 5'h0C, 5'h12};
    logic [3:0]  dq [$];
    logic        sq [$];
    int          miscompares, checks_done, seed, cyc, k, st;
    swd_sensor #(.INPUT_NUM(3'h3), .TICK_CYC(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .manual_en(1'b0), .manual_act(1'b0), .tx_sw_stb_r(sw_stb),
        .tx_sw_val_r(sw_val), .tx_dim_stb_r(dim_stb),
        .tx_dim_val_r(dim_val), .tx_obj_r());
    swd_act_model u_act (.pclk(pclk), .presetn(presetn), .sw_stb(sw_stb),
        .sw_val(sw_val), .dim_stb(dim_stb), .dim_val(dim_val), .on_r(fb_on));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (sw_stb === 1'b1)
            sq.push_back(sw_val);
        if (dim_stb === 1'b1)
            dq.push_back(dim_val);
        if (cyc == 80000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ********
    // Helpers
    // ********
    function automatic logic [31:0] cfg(input logic [1:0] sh,
        input logic [2:0] dir, input logic md, input logic [2:0] stp,
        input logic ct, input logic od);
        return {8'h00, od, ct, stp, md, dir, sh, 13'h0000};
    endfunction
    // The toggle case inverts the value sent by the previous short press.
    function automatic logic [4:0] sh_exp(input int k, input logic cur);
        return (k == 3) ? 5'h00 : {4'h8, k == 0 || (k == 2 && !cur)};
    endfunction
    function automatic logic [4:0] dpop();
        return (dq.size() > 0) ? {1'b1, dq.pop_front()} : 5'h00;
    endfunction
    function automatic logic [4:0] spop();
        return (sq.size() > 0) ? {4'h8, sq.pop_front()} : 5'h00;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic press(input int h);
        pin_in <= 1'b1;
        wt(h);
        pin_in <= 1'b0;
        wt(200);
    endtask
    task automatic chk_reg(input string n, input logic [31:0] x,
        input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_tel(input string n, input logic [4:0] x,
        input logic [4:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    initial begin
        {psel, penable, pwrite, pin_in, presetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        seed = 14383;
        wt(5);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk_reg("cfg", 32'h0001_4063, rd);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk_reg("objnum", 32'h002A_2928, rd);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        apb(1'b0, 8'h14, 32'h0000_0000);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, cfg(k[1:0], 3'h0, 1'b0, 3'h0, 1'b0, 1'b0));
            press(200 + ($random(seed) & 2047));
            e = sh_exp(k, e[0]);
            chk_tel("short", e, spop());
        end
        $display("test short done");
        for (k = 0; k < 7; k++) begin
            apb(1'b1, 8'h00, cfg(2'h0, lt[k][4:2], 1'b0, 3'h0, 1'b0, 1'b0));
            if (lt[k][1]) begin
                press(500);
                chk_tel("on", 5'h11, spop());
            end
            press(3100 + ($random(seed) & 511));
            chk_tel("dir", {1'b1, lt[k][0], 3'h1}, dpop());
            chk_tel("stop", 5'h10, dpop());
        end
        $display("test direction done");
        st = $unsigned($random(seed)) % 7;
        apb(1'b1, 8'h00, cfg(2'h3, 3'h0, 1'b1, st[2:0], 1'b0, 1'b0));
        press(9500);
        repeat (3) chk_tel("step", {2'b11, st[2:0] + 3'h1}, dpop());
        chk_tel("after", 5'h00, dpop());
        $display("test stepwise done");
        apb(1'b1, 8'h00, cfg(2'h3, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0));
        pin_in <= 1'b1;
        wt(3100);
        apb(1'b1, 8'h04, 32'h0000_0001);
        apb(1'b1, 8'h08, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk_reg("switch", 32'h0000_0000, rd);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk_reg("block", 32'h0000_0001, rd);
        pin_in <= 1'b0;
        wt(300);
        chk_tel("start", 5'h19, dpop());
        chk_tel("blocked", 5'h00, dpop());
        apb(1'b1, 8'h04, 32'h0000_0000);
        wt(20);
        chk_tel("unblock", 5'h10, dpop());
        $display("test block done");
        apb(1'b1, 8'h00, cfg(2'h3, 3'h0, 1'b0, 3'h0, 1'b1, 1'b1));
        wt(20);
        pin_in <= 1'b1;
        wt(300);
        dq.delete();
        pin_in <= 1'b0;
        wt(5);
        chk_tel("onlydim", 5'h19, dpop());
        wt(200);
        apb(1'b1, 8'h00, cfg(2'h2, 3'h2, 1'b0, 3'h0, 1'b0, 1'b0));
        apb(1'b1, 8'h08, 32'h0000_0000);
        wt(200);
        dq.delete();
        sq.delete();
        press(3300);
        chk_tel("forced", 5'h19, dpop());
        apb(1'b1, 8'h08, {31'h0000_0000, fb_on});
        press(500);
        chk_tel("toggle", 5'h10, spop());
        $display("test contact and toggle done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
